// ===== verilog/isms_top.sv
/*
 * fifo trigger select, system mode and interrupt source registers.
 * assumes the host port decodes reads and writes into one-cycle
 * strobes, and that the function blocks, fifo and data path give
 * their event levels and source-register read strobes on core_clk.
 */
`timescale 1ns/1ps
module isms_top
    import isms_pkg::*;
#(
    parameter int ODR_FAST_CYC = ISMS_FAST_CYC,
    parameter int ODR_SLOW_CYC = ISMS_SLOW_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    input wire logic [7:0] int_enable,
    input wire logic [7:0] wake_enable,
    input wire logic active_en,
    input wire logic auto_sleep_en,
    input wire logic [ISMS_LIM_W-1:0] inactivity_limit,
    input wire logic transient_active,
    input wire logic orientation_changed,
    input wire logic tap_active,
    input wire logic fall_motion_active,
    input wire logic xyz_new_data,
    input wire logic xyz_overrun,
    input wire logic fifo_overflow,
    input wire logic [ISMS_CNT_W-1:0] fifo_sample_count,
    input wire logic [ISMS_CNT_W-1:0] fifo_watermark,
    input wire logic fifo_gate_error_det,
    input wire logic fifo_empty,
    input wire logic fifo_status_read,
    input wire logic transient_source_read,
    input wire logic orientation_status_read,
    input wire logic tap_source_read,
    input wire logic fall_motion_source_read,
    input wire logic xyz_data_read,
    output logic fifo_trigger_q,
    output isms_mode_t system_mode_q,
    output logic odr_low_q
);
    logic [7:0] trig_sel_q;
    logic fifo_gate_error_q;
    logic [ISMS_AGE_W-1:0] gate_error_age_q;
    logic [7:0] mode_word;
    logic [7:0] rdata_d;
    logic mode_rd;
    logic odr_tick;
    logic aslp_evt;
    logic activity;
    logic wake_evt;
    logic fifo_level;

    isms_flag_if #(.W(8)) st_if ();
    isms_flag_if #(.W(8)) tr_if ();

    assign mode_rd = reg_rd && reg_addr == ISMS_MODE_OFS;

    // host write of the trigger select; reserved bits never stored
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            trig_sel_q <= ISMS_ZERO;
        end else if (reg_wr && reg_addr == ISMS_TRIG_OFS) begin
            trig_sel_q <= reg_wdata & ISMS_TRIG_MASK;
        end
    end

    // equality, not >=: a fifo sitting above its mark sets only once
    assign fifo_level = fifo_overflow
        || fifo_sample_count == fifo_watermark;

    // event levels, each but the sleep bit gated by its own interrupt enable
    always_comb begin
        st_if.lvl = ISMS_ZERO;
        st_if.lvl[ISMS_B_ASLP] = aslp_evt;
        st_if.lvl[ISMS_B_FIFO] =
            int_enable[ISMS_B_FIFO] & fifo_level;
        st_if.lvl[ISMS_B_TRANS] =
            int_enable[ISMS_B_TRANS] & transient_active;
        st_if.lvl[ISMS_B_ORIENT] =
            int_enable[ISMS_B_ORIENT] & orientation_changed;
        st_if.lvl[ISMS_B_TAP] =
            int_enable[ISMS_B_TAP] & tap_active;
        st_if.lvl[ISMS_B_FALL] =
            int_enable[ISMS_B_FALL] & fall_motion_active;
        st_if.lvl[ISMS_B_DRDY] = int_enable[ISMS_B_DRDY]
            & (xyz_new_data | xyz_overrun);
    end

    // each flag drops only on a read of its own source register
    always_comb begin
        st_if.clr = ISMS_ZERO;
        st_if.clr[ISMS_B_ASLP] = mode_rd;
        st_if.clr[ISMS_B_FIFO] = fifo_status_read;
        st_if.clr[ISMS_B_TRANS] = transient_source_read;
        st_if.clr[ISMS_B_ORIENT] = orientation_status_read;
        st_if.clr[ISMS_B_TAP] = tap_source_read;
        st_if.clr[ISMS_B_FALL] = fall_motion_source_read;
        // reading the data status register alone does not count
        st_if.clr[ISMS_B_DRDY] = xyz_data_read;
    end

    // trigger indications share levels and clears, masked by select
    assign tr_if.lvl = st_if.lvl & trig_sel_q;
    assign tr_if.clr = st_if.clr;

    isms_flag_bank #(
        .W(8),
        .MASK(ISMS_SRC_MASK)
    ) u_status (
        .clk(core_clk),
        .rstn(rstn),
        .fi(st_if)
    );

    isms_flag_bank #(
        .W(8),
        .MASK(ISMS_TRIG_MASK)
    ) u_trigger (
        .clk(core_clk),
        .rstn(rstn),
        .fi(tr_if)
    );

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fifo_trigger_q <= 1'b0;
        end else begin
            fifo_trigger_q <= |tr_if.q;
        end
    end

    // the sleep bit itself is not activity; activity only restarts the idle count
    assign activity = |(st_if.lvl & ISMS_SRC_MASK
        & ~(ISMS_ZERO | (8'h01 << ISMS_B_ASLP)));
    // the sleep bit is a result of a mode change, never a cause of one
    assign wake_evt = |(st_if.lvl & wake_enable
        & ~(ISMS_ZERO | (8'h01 << ISMS_B_ASLP)));

    isms_sleep_ctl #(
        .FAST_CYC(ODR_FAST_CYC),
        .SLOW_CYC(ODR_SLOW_CYC)
    ) u_sleep (
        .clk(core_clk),
        .rstn(rstn),
        .active_en(active_en),
        .auto_en(auto_sleep_en),
        .limit(inactivity_limit),
        .activity(activity),
        .wake_evt(wake_evt),
        .mode_q(system_mode_q),
        .odr_low_q(odr_low_q),
        .tick_q(odr_tick),
        .aslp_evt_q(aslp_evt)
    );

    // gate error: detection wins over an emptying fifo
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fifo_gate_error_q <= 1'b0;
        end else if (fifo_gate_error_det) begin
            fifo_gate_error_q <= 1'b1;
        end else if (fifo_empty) begin
            fifo_gate_error_q <= 1'b0;
        end
    end

    // age sticks at its top value rather than wrapping
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            gate_error_age_q <= '0;
        end else if (!fifo_gate_error_q) begin
            gate_error_age_q <= '0;
        end else if (fifo_empty && !fifo_gate_error_det) begin
            gate_error_age_q <= '0;
        end else if (odr_tick && gate_error_age_q != ISMS_AGE_MAX) begin
            gate_error_age_q <= gate_error_age_q + 1'b1;
        end
    end

    assign mode_word = {fifo_gate_error_q, gate_error_age_q,
        system_mode_q};

    // unmapped addresses read zero
    always_comb begin
        rdata_d = ISMS_ZERO;
        unique case (reg_addr)
            ISMS_TRIG_OFS: rdata_d = trig_sel_q & ISMS_TRIG_MASK;
            ISMS_MODE_OFS: rdata_d = mode_word;
            ISMS_SRC_OFS: rdata_d = st_if.q & ISMS_SRC_MASK;
            default: rdata_d = ISMS_ZERO;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata_q <= ISMS_ZERO;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    trig_write_a: assert property (
        (reg_wr && reg_addr == ISMS_TRIG_OFS)
        |=> (trig_sel_q == ($past(reg_wdata) & ISMS_TRIG_MASK)))
        else $error("trigger select not written");
    mode_read_a: assert property (
        mode_rd |=> (reg_rdata_q == $past(mode_word)
            && reg_rdata_q[1:0] != 2'b11))
        else $error("mode register read wrong");
    rsvd_zero_a: assert property (
        (reg_rd && reg_addr == ISMS_SRC_OFS)
        |=> (reg_rdata_q[ISMS_B_RSVD] == 1'b0
            && reg_rdata_q == ($past(st_if.q) & ISMS_SRC_MASK)))
        else $error("status read or reserved bit wrong");
    gate_set_a: assert property (
        fifo_gate_error_det |=> fifo_gate_error_q)
        else $error("gate error not flagged");
    gate_clear_a: assert property (
        (fifo_empty && !fifo_gate_error_det)
        |=> (!fifo_gate_error_q ##1 gate_error_age_q == '0))
        else $error("gate error or age not cleared");
    age_count_a: assert property (
        (fifo_gate_error_q && odr_tick && !fifo_empty
            && gate_error_age_q != ISMS_AGE_MAX)
        |=> (gate_error_age_q == $past(gate_error_age_q) + 1'b1))
        else $error("gate error age not counting");
    drdy_hold_a: assert property (
        (st_if.q[ISMS_B_DRDY] && !xyz_data_read)
        |=> st_if.q[ISMS_B_DRDY])
        else $error("data ready lost without data read");
    aslp_clear_a: assert property (
        (mode_rd && !aslp_evt && !$rose(aslp_evt))
        |=> !st_if.q[ISMS_B_ASLP])
        else $error("sleep bit not cleared by mode read");
    trig_fire_a: assert property (
        (tr_if.q != '0) |=> fifo_trigger_q)
        else $error("trigger flag did not reach output");
    trig_rise_a: assert property (
        (|(tr_if.lvl & ~$past(tr_if.lvl))) |-> ##2 fifo_trigger_q)
        else $error("trigger edge did not reach output");
    // per-function set and clear, in status register layout
    aslp_set_a: assert property (
        $rose(aslp_evt) |=> st_if.q[ISMS_B_ASLP])
        else $error("sleep bit not set by mode change");
    fifo_set_a: assert property (
        $rose(st_if.lvl[ISMS_B_FIFO]) |=> st_if.q[ISMS_B_FIFO])
        else $error("fifo bit not set by its event");
    trans_set_a: assert property (
        $rose(st_if.lvl[ISMS_B_TRANS]) |=> st_if.q[ISMS_B_TRANS])
        else $error("transient bit not set by its event");
    orient_set_a: assert property (
        $rose(st_if.lvl[ISMS_B_ORIENT]) |=> st_if.q[ISMS_B_ORIENT])
        else $error("orientation bit not set by its event");
    tap_set_a: assert property (
        $rose(st_if.lvl[ISMS_B_TAP]) |=> st_if.q[ISMS_B_TAP])
        else $error("tap bit not set by its event");
    fall_set_a: assert property (
        $rose(st_if.lvl[ISMS_B_FALL]) |=> st_if.q[ISMS_B_FALL])
        else $error("fall bit not set by its event");
    drdy_set_a: assert property (
        $rose(st_if.lvl[ISMS_B_DRDY]) |=> st_if.q[ISMS_B_DRDY])
        else $error("data ready bit not set by new data");
    fifo_clear_a: assert property (
        (fifo_status_read && st_if.q[ISMS_B_FIFO]
            && !$rose(st_if.lvl[ISMS_B_FIFO])) |=> !st_if.q[ISMS_B_FIFO])
        else $error("fifo bit not cleared by its read");
    trans_clear_a: assert property (
        (transient_source_read && st_if.q[ISMS_B_TRANS]
            && !$rose(st_if.lvl[ISMS_B_TRANS])) |=> !st_if.q[ISMS_B_TRANS])
        else $error("transient bit not cleared by its read");
    orient_clear_a: assert property (
        (orientation_status_read && st_if.q[ISMS_B_ORIENT]
            && !$rose(st_if.lvl[ISMS_B_ORIENT])) |=> !st_if.q[ISMS_B_ORIENT])
        else $error("orientation bit not cleared by its read");
    tap_clear_a: assert property (
        (tap_source_read && st_if.q[ISMS_B_TAP]
            && !$rose(st_if.lvl[ISMS_B_TAP])) |=> !st_if.q[ISMS_B_TAP])
        else $error("tap bit not cleared by its read");
    fall_clear_a: assert property (
        (fall_motion_source_read && st_if.q[ISMS_B_FALL]
            && !$rose(st_if.lvl[ISMS_B_FALL])) |=> !st_if.q[ISMS_B_FALL])
        else $error("fall bit not cleared by its read");
    drdy_clear_a: assert property (
        (xyz_data_read && st_if.q[ISMS_B_DRDY]
            && !$rose(st_if.lvl[ISMS_B_DRDY])) |=> !st_if.q[ISMS_B_DRDY])
        else $error("data ready bit not cleared by data read");
    src_read_keep_a: assert property (
        (reg_rd && reg_addr == ISMS_SRC_OFS && st_if.clr == ISMS_ZERO)
        |=> ((st_if.q & $past(st_if.q)) == $past(st_if.q)))
        else $error("status read cleared a flag");
    age_zero_a: assert property (
        !fifo_gate_error_q |=> (gate_error_age_q == '0))
        else $error("gate error age not held at zero");

    trig_cv: cover property ($rose(fifo_trigger_q));
    gate_cv: cover property (fifo_gate_error_q ##1 !fifo_gate_error_q);
    drdy_cv: cover property (st_if.q[ISMS_B_DRDY] && xyz_data_read);
endmodule

// ===== verilog/isms_pkg.sv
/*
 * constants for the interrupt source, system mode and fifo trigger
 * select registers: offsets, bit positions, mode codes, rates.
 * assumes a register port with byte addresses and one core clock.
 */
package isms_pkg;
    localparam logic [7:0] ISMS_TRIG_OFS = 8'h0a;
    localparam logic [7:0] ISMS_MODE_OFS = 8'h0b;
    localparam logic [7:0] ISMS_SRC_OFS = 8'h0c;
    localparam logic [7:0] ISMS_ZERO = 8'h00;
    localparam logic [7:0] ISMS_TRIG_MASK = 8'h3c;
    localparam logic [7:0] ISMS_SRC_MASK = 8'hfd;
    localparam int ISMS_B_ASLP = 7;
    localparam int ISMS_B_FIFO = 6;
    localparam int ISMS_B_TRANS = 5;
    localparam int ISMS_B_ORIENT = 4;
    localparam int ISMS_B_TAP = 3;
    localparam int ISMS_B_FALL = 2;
    localparam int ISMS_B_RSVD = 1;
    localparam int ISMS_B_DRDY = 0;
    localparam int ISMS_AGE_W = 5;
    localparam int ISMS_CNT_W = 6;
    localparam int ISMS_LIM_W = 8;
    localparam int ISMS_DIV_W = 24;
    localparam logic [ISMS_AGE_W-1:0] ISMS_AGE_MAX = 5'h1f;
    localparam int ISMS_CLK_HZ = 125_000_000;
    localparam int ISMS_ODR_FAST_HZ = 800;
    localparam int ISMS_ODR_SLOW_HZ = 50;
    localparam int ISMS_FAST_CYC = ISMS_CLK_HZ / ISMS_ODR_FAST_HZ;
    localparam int ISMS_SLOW_CYC = ISMS_CLK_HZ / ISMS_ODR_SLOW_HZ;
    typedef enum logic [1:0] {
        ISMS_STANDBY = 2'b00,
        ISMS_WAKE = 2'b01,
        ISMS_SLEEP = 2'b10
    } isms_mode_t;
endpackage

// ===== verilog/isms_flag_if.sv
/*
 * carrier between the top and a sticky flag bank: set levels,
 * clear strobes and the flags themselves.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface isms_flag_if #(parameter int W = 8);
    logic [W-1:0] lvl;
    logic [W-1:0] clr;
    logic [W-1:0] q;
    modport owner (output lvl, output clr, input q);
    modport bank (input lvl, input clr, output q);
endinterface

// ===== verilog/isms_flag_bank.sv
/*
 * bank of sticky flags set on a rising edge of their level and
 * cleared by a strobe; set wins over clear.
 * assumes levels and strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
module isms_flag_bank
    import isms_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] MASK = '1
) (
    input wire logic clk,
    input wire logic rstn,
    isms_flag_if.bank fi
);
    logic [W-1:0] prev_q;
    logic [W-1:0] rise;
    logic [W-1:0] flag_d;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            if (MASK[i]) begin : g_live
                // edge, not level: a held event sets once
                assign rise[i] = fi.lvl[i] & ~prev_q[i];
                // set wins over a clear in the same cycle
                assign flag_d[i] = rise[i] | (fi.q[i] & ~fi.clr[i]);
            end else begin : g_rsvd
                assign rise[i] = 1'b0;
                assign flag_d[i] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_q <= '0;
        end else begin
            prev_q <= fi.lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fi.q <= '0;
        end else begin
            fi.q <= flag_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    set_wins_a: assert property (
        (|(rise & fi.clr)) |=>
        ((fi.q & $past(rise & fi.clr)) == $past(rise & fi.clr)))
        else $error("flag lost when set met clear");
    edge_only_a: assert property (
        (fi.q == '0 && rise == '0) |=> (fi.q == '0))
        else $error("flag set without a rising edge");
    read_clear_a: assert property (
        (|(fi.clr & ~rise & fi.q)) |=>
        ((fi.q & $past(fi.clr & ~rise)) == '0))
        else $error("flag not cleared by its read");
endmodule

// ===== verilog/isms_sleep_ctl.sv
/*
 * standby, wake and sleep sequencing with the data-rate divider.
 * assumes activity and wake levels come from the status logic.
 */
`timescale 1ns/1ps
module isms_sleep_ctl
    import isms_pkg::*;
#(
    parameter int FAST_CYC = ISMS_FAST_CYC,
    parameter int SLOW_CYC = ISMS_SLOW_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic active_en,
    input wire logic auto_en,
    input wire logic [ISMS_LIM_W-1:0] limit,
    input wire logic activity,
    input wire logic wake_evt,
    output isms_mode_t mode_q,
    output logic odr_low_q,
    output logic tick_q,
    output logic aslp_evt_q
);
    localparam logic [ISMS_DIV_W-1:0] FAST_LD = ISMS_DIV_W'(FAST_CYC - 1);
    localparam logic [ISMS_DIV_W-1:0] SLOW_LD = ISMS_DIV_W'(SLOW_CYC - 1);
    localparam logic [ISMS_LIM_W-1:0] IDLE_MAX = '1;
    logic [ISMS_DIV_W-1:0] div_q;
    logic [ISMS_LIM_W-1:0] idle_q;
    isms_mode_t mode_d;

    // data-rate enable pulse; period follows the current rate
    always_ff @(posedge clk) begin
        if (!rstn) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else if (mode_q == ISMS_STANDBY) begin
            div_q <= FAST_LD;
            tick_q <= 1'b0;
        end else if (div_q == '0) begin
            div_q <= odr_low_q ? SLOW_LD : FAST_LD;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q - 1'b1;
            tick_q <= 1'b0;
        end
    end

    // saturates so a long quiet spell cannot wrap back to zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            idle_q <= '0;
        end else if (activity || mode_q != ISMS_WAKE) begin
            idle_q <= '0;
        end else if (tick_q && idle_q != IDLE_MAX) begin
            idle_q <= idle_q + 1'b1;
        end
    end

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            ISMS_STANDBY: begin
                if (active_en) begin
                    mode_d = ISMS_WAKE;
                end
            end
            ISMS_WAKE: begin
                if (auto_en && tick_q && idle_q > limit) begin
                    mode_d = ISMS_SLEEP;
                end
            end
            ISMS_SLEEP: begin
                if (wake_evt || !auto_en) begin
                    mode_d = ISMS_WAKE;
                end
            end
            default: begin
                mode_d = ISMS_STANDBY;
            end
        endcase
        if (!active_en) begin
            mode_d = ISMS_STANDBY;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_q <= ISMS_STANDBY;
            odr_low_q <= 1'b0;
            aslp_evt_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            odr_low_q <= (mode_d == ISMS_SLEEP);
            aslp_evt_q <= (mode_q == ISMS_WAKE && mode_d == ISMS_SLEEP)
                || (mode_q == ISMS_SLEEP && mode_d == ISMS_WAKE);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sleep_entry_a: assert property (
        (active_en && auto_en && mode_q == ISMS_WAKE && tick_q
            && idle_q > limit)
        |=> (mode_q == ISMS_SLEEP && odr_low_q && aslp_evt_q))
        else $error("no sleep after inactivity");
    wake_entry_a: assert property (
        (active_en && mode_q == ISMS_SLEEP && wake_evt)
        |=> (mode_q == ISMS_WAKE && !odr_low_q && aslp_evt_q))
        else $error("no wake on wake event");
    sleep_cv: cover property (mode_q == ISMS_WAKE ##1 mode_q == ISMS_SLEEP);
    wake_cv: cover property (mode_q == ISMS_SLEEP ##1 mode_q == ISMS_WAKE);
endmodule

// ===== bench/isms_host_model.sv
/*
 * host side of the register port: byte reads and writes as
 * one-cycle strobes, driven 1 ns after the rising edge.
 * assumes callers enter its tasks 1 ns after a rising edge.
 */
`timescale 1ns/1ps
module isms_host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata_q,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h5a;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'ha5;
    end

    // released lines show the inverse, so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        // an idle edge, so a following request never lands in this step
        @(posedge core_clk);
        #1;
    endtask

    // data is picked up one edge after the taking edge, it holds anyway
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(posedge core_clk);
        #1;
        d = reg_rdata_q;
    endtask
endmodule

// ===== bench/tb.sv
/*
 * self-checking bench for the trigger select, mode and interrupt
 * source registers, expectations worked out from the register map.
 * assumes short data-rate periods of 8 and 16 cycles.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    import isms_pkg::*;
    localparam int FAST = 8;
    logic core_clk = 0, rstn = 0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, d, sel;
    logic reg_rd, reg_wr, fifo_trigger_q, odr_low_q;
    isms_mode_t system_mode_q;
    logic [7:0] int_enable = 8'hff, wake_enable = 8'h00;
    logic active_en = 0, auto_sleep_en = 0;
    logic [7:0] inactivity_limit = 8'hff;
    logic [3:0] ev = 4'h0, clr = 4'h0;
    logic xyz_new_data = 0, xyz_overrun = 0, fifo_overflow = 0;
    logic [5:0] cnt = 6'h00, wm = 6'h3f;
    logic gate_det = 0, fifo_empty = 0, fifo_rd = 0, xyz_rd = 0;
    int miscompares = 0, samples_checked = 0, b;

    initial forever #4 core_clk = ~core_clk;

    isms_host_model host_u (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata));

    // event levels and clear strobes: index i maps to status bit i+2
    isms_top #(.ODR_FAST_CYC(FAST), .ODR_SLOW_CYC(16)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .int_enable(int_enable),
        .wake_enable(wake_enable), .active_en(active_en),
        .auto_sleep_en(auto_sleep_en), .inactivity_limit(inactivity_limit),
        .transient_active(ev[3]), .orientation_changed(ev[2]),
        .tap_active(ev[1]), .fall_motion_active(ev[0]),
        .xyz_new_data(xyz_new_data), .xyz_overrun(xyz_overrun),
        .fifo_overflow(fifo_overflow), .fifo_sample_count(cnt),
        .fifo_watermark(wm), .fifo_gate_error_det(gate_det),
        .fifo_empty(fifo_empty), .fifo_status_read(fifo_rd),
        .transient_source_read(clr[3]), .orientation_status_read(clr[2]),
        .tap_source_read(clr[1]), .fall_motion_source_read(clr[0]),
        .xyz_data_read(xyz_rd), .fifo_trigger_q(fifo_trigger_q),
        .system_mode_q(system_mode_q), .odr_low_q(odr_low_q));

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic end_sim();
        $display("checked %0d miscompared %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [7:0] e);
        logic [7:0] q;
        host_u.rd(a, q);
        `CHK(nm, e, q)
    endtask

    // bounded: a mode that never comes counts as a miscompare
    task automatic wait_mode(input isms_mode_t m, input int lim);
        int n;
        n = 0;
        while (system_mode_q !== m && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) begin
            miscompares++;
            $display("BAD wait_mode exp %h got %h", m, system_mode_q);
            end_sim();
        end
    endtask

    initial begin
        void'($urandom(92253));
        tick(2);
        rstn = 1;
        rdchk("trig_rst", ISMS_TRIG_OFS, 8'h00);
        rdchk("mode_rst", ISMS_MODE_OFS, 8'h00);
        rdchk("src_rst", ISMS_SRC_OFS, 8'h00);
        rdchk("unmapped", 8'h0d, 8'h00);
        sel = 8'($urandom);
        host_u.wr(ISMS_TRIG_OFS, sel);
        host_u.wr(ISMS_MODE_OFS, 8'hff);
        host_u.wr(ISMS_SRC_OFS, 8'hff);
        rdchk("trig_rw", ISMS_TRIG_OFS, sel & 8'h3c);
        rdchk("mode_ro", ISMS_MODE_OFS, 8'h00);
        rdchk("src_ro", ISMS_SRC_OFS, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            b = i + 2;
            int_enable[b] = 1'b0;
            ev[i] = 1'b1;
            tick(2);
            rdchk("src_masked", ISMS_SRC_OFS, 8'h00);
            ev[i] = 1'b0;
            tick(1);
            int_enable[b] = 1'b1;
            ev[i] = 1'b1;
            tick(2);
            `CHK("trig_out", sel[b], fifo_trigger_q)
            rdchk("src_set", ISMS_SRC_OFS, 8'(1 << b));
            rdchk("src_keep", ISMS_SRC_OFS, 8'(1 << b));
            clr[i] = 1'b1;
            tick(1);
            clr[i] = 1'b0;
            tick(2);
            rdchk("src_clr", ISMS_SRC_OFS, 8'h00);
            `CHK("trig_clr", 1'b0, fifo_trigger_q)
            ev[i] = 1'b0;
        end
        $display("test functions done");
        for (int k = 0; k < 2; k++) begin
            {xyz_overrun, xyz_new_data} = 2'(1 << k);
            tick(2);
            rdchk("drdy_set", ISMS_SRC_OFS, 8'h01);
            rdchk("status0", 8'h00, 8'h00);
            rdchk("drdy_keep", ISMS_SRC_OFS, 8'h01);
            xyz_rd = 1'b1;
            tick(1);
            xyz_rd = 1'b0;
            {xyz_overrun, xyz_new_data} = 2'b00;
            tick(1);
            rdchk("drdy_clr", ISMS_SRC_OFS, 8'h00);
        end
        wm = 6'($urandom_range(1, 31));
        cnt = wm - 6'h01;
        tick(2);
        rdchk("fifo_below", ISMS_SRC_OFS, 8'h00);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) cnt = wm;
            else fifo_overflow = 1'b1;
            tick(2);
            rdchk("fifo_set", ISMS_SRC_OFS, 8'h40);
            fifo_rd = 1'b1;
            tick(1);
            fifo_rd = 1'b0;
            cnt = 6'h00;
            fifo_overflow = 1'b0;
            tick(1);
            rdchk("fifo_clr", ISMS_SRC_OFS, 8'h00);
        end
        $display("test data and fifo done");
        gate_det = 1'b1;
        tick(1);
        gate_det = 1'b0;
        tick(1);
        host_u.rd(ISMS_MODE_OFS, d);
        `CHK("gate_err", 1'b1, d[7])
        fifo_empty = 1'b1;
        tick(3);
        fifo_empty = 1'b0;
        rdchk("gate_clr", ISMS_MODE_OFS, 8'h00);
        active_en = 1'b1;
        wait_mode(ISMS_WAKE, 4);
        `CHK("mode_wake", ISMS_WAKE, system_mode_q)
        gate_det = 1'b1;
        tick(1);
        gate_det = 1'b0;
        tick(4 * FAST);
        host_u.rd(ISMS_MODE_OFS, d);
        // tick phase is free running, so allow one period either way
        `CHK("age_run", 1'b1, (d[6:2] >= 5'd3 && d[6:2] <= 5'd5))
        fifo_empty = 1'b1;
        tick(3);
        fifo_empty = 1'b0;
        rdchk("age_clr", ISMS_MODE_OFS, 8'h01);
        $display("test gate error done");
        inactivity_limit = 8'($urandom_range(1, 3));
        auto_sleep_en = 1'b1;
        wait_mode(ISMS_SLEEP, 100);
        `CHK("odr_low", 1'b1, odr_low_q)
        tick(2);
        rdchk("aslp_set", ISMS_SRC_OFS, 8'h80);
        rdchk("mode_sleep", ISMS_MODE_OFS, 8'h02);
        rdchk("aslp_clr", ISMS_SRC_OFS, 8'h00);
        wake_enable = 8'h08;
        ev[1] = 1'b1;
        wait_mode(ISMS_WAKE, 20);
        `CHK("odr_fast", 1'b0, odr_low_q)
        tick(2);
        rdchk("wake_src", ISMS_SRC_OFS, 8'h88);
        ev[1] = 1'b0;
        $display("test sleep and wake done");
        rstn = 1'b0;
        tick(2);
        `CHK("mode_in_rst", ISMS_STANDBY, system_mode_q)
        // standby requested, or the first edge after release wakes it
        active_en = 1'b0;
        rstn = 1'b1;
        rdchk("trig_rst2", ISMS_TRIG_OFS, 8'h00);
        rdchk("mode_rst2", ISMS_MODE_OFS, 8'h00);
        $display("test second reset done");
        end_sim();
    end
endmodule
